// file: dv/dic_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module dic_adc_model
	import dic_pkg::*;
(
	input  wire logic                    clk_i,
	input  wire logic                    resetn_i,
	input  wire logic                    start_i,
	input  wire logic [1:0]              chan_i,
	input  wire logic [1:0]              cur_i,
	input  wire logic                    slow_i,
	input  wire logic signed [RAW_W-1:0] sh1_i,
	input  wire logic signed [RAW_W-1:0] sh2_i,
	output logic                         done_o,
	output logic signed [RAW_W-1:0]      raw_o
);
	logic [3:0]              cnt_ff;
	logic signed [RAW_W-1:0] val_ff;
	// diode steps: 2*(40-base)-(40-base) = 40-base
	wire logic signed [RAW_W-1:0] nxt_val = (cur_i != CUR_BASE) ? 11'sh028 :
		(chan_i == CH_SH1) ? sh1_i : (chan_i == CH_SH2) ? sh2_i : 11'sh00A;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_ff <= 4'h0;
			done_o <= 1'b0;
			raw_o  <= 11'sh000;
			val_ff <= 11'sh000;
		end else begin
			done_o <= (cnt_ff == 4'h1);
			// the code is only valid with done, so it churns meanwhile
			raw_o <= (cnt_ff == 4'h1) ? val_ff : ~raw_o;
			if (start_i) begin
				cnt_ff <= slow_i ? 4'h9 : 4'h2;
				val_ff <= nxt_val;
			end else if (cnt_ff != 4'h0) begin
				cnt_ff <= cnt_ff - 4'h1;
			end
		end
	end
endmodule // dic_adc_model
`default_nettype wire

// file: dv/dual_input_channel_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dual_input_channel_config_bench;
	import dic_pkg::*;
	logic              clk_i = 1'b0;
	logic              resetn_i = 1'b0;
	logic [7:0]        addr = 8'h00;
	logic              rd_i = 1'b0;
	logic              wr_i = 1'b0;
	logic [31:0]       wdat = 32'h0;
	logic [31:0]       rdat;
	logic              wq, start, done, th1, th2, rem, irq;
	logic [1:0]        chan, cur;
	logic signed [10:0] raw;
	logic signed [10:0] sh1 = 11'sh000;
	logic signed [10:0] sh2 = 11'sh000;
	logic              slow = 1'b0;
	logic [3:0]        fault = 4'h0;
	logic [31:0]       rd;
	int                err_total = 0;
	int                checks_done = 0;
	wire logic [2:0]   mode_w = {th1, th2, rem};

	always #4 clk_i = ~clk_i;

	dic_top uut (.clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(addr),
		.avs_read_i(rd_i), .avs_write_i(wr_i), .avs_writedata_i(wdat),
		.avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wq), .adc_start_o(start), .adc_chan_o(chan),
		.adc_cur_o(cur), .adc_done_i(done), .adc_raw_i(raw),
		.sensor_fault_i(fault), .thermistor_one_o(th1),
		.thermistor_two_o(th2), .second_remote_diode_o(rem), .irq_o(irq));
	dic_adc_model adc (.clk_i(clk_i), .resetn_i(resetn_i), .start_i(start),
		.chan_i(chan), .cur_i(cur), .slow_i(slow), .sh1_i(sh1), .sh2_i(sh2),
		.done_o(done), .raw_o(raw));

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		addr <= {idx, 2'b00};
		wr_i <= w;
		rd_i <= !w;
		wdat <= {24'h0, d};
		n = 0;
		// waitrequest is read at the rising edge, before that edge updates it
		do begin
			@(posedge clk_i);
			n++;
		end while (wq !== 1'b0 && n < 50);
		if (n >= 50)
			err_total++;
		rd = rdat;
		rd_i <= 1'b0;
		wr_i <= 1'b0;
		// let the write settle so callers see its effect on irq
		@(posedge clk_i);
	endtask

	task automatic poll(input string nm, input logic [5:0] idx, input logic [7:0] e);
		rd = 32'hFFFF_FFFF;
		for (int n = 0; n < 300 && rd !== {24'h0, e}; n++) bus(1'b0, idx, 8'h00);
		chk(nm, rd, {24'h0, e});
	endtask

	// mode pins only change at the start of a shared-channel cycle
	task automatic pollm(input logic [2:0] e, input logic [2:0] m);
		for (int n = 0; n < 600 && (mode_w & m) !== e; n++) @(posedge clk_i);
		chk("mode", {29'h0, mode_w & m}, {29'h0, e});
	endtask

	task automatic t_reset;
		poll("cfg3", IDX_CFG_THREE, 8'hC0);
		chk("mode", {29'h0, mode_w}, 32'h6);
		poll("cfg2", IDX_CFG_TWO, 8'h00);
		poll("hi1", IDX_HI_ONE, 8'hFF);
		poll("lo2", IDX_LO_TWO, 8'h00);
		bus(1'b1, IDX_ST_ONE, 8'hFF);
		poll("st1 ro", IDX_ST_ONE, 8'h00);
		poll("unmapped", 6'h3F, 8'h00);
	endtask

	task automatic t_sat;
		bus(1'b1, IDX_FAN_CFG, 8'h00);
		bus(1'b1, IDX_CFG_TWO, 8'h10);
		bus(1'b1, IDX_CFG_THREE, 8'h00);
		pollm(3'b000, 3'b111);
		bus(1'b1, IDX_CFG_THREE, 8'h80);
		pollm(3'b100, 3'b111);
		sh1 <= 11'sh12C;
		sh2 <= 11'sh020;
		poll("res2 mid", IDX_RES_SH2, 8'h20);
		sh2 <= -11'sh005;
		poll("res1 high", IDX_RES_SH1, 8'hFF);
		poll("res2 low", IDX_RES_SH2, 8'h00);
		sh1 <= 11'sh0C0;
		poll("res1 mid", IDX_RES_SH1, 8'hC0);
		poll("local", IDX_RES_LOC, 8'h1E);
		poll("remote", IDX_RES_REM1, 8'h1E);
	endtask

	task automatic t_limit;
		sh2 <= 11'sh032;
		bus(1'b1, IDX_HI_ONE, 8'h64);
		poll("ool1", IDX_ST_ONE, 8'h40);
		chk("irq on", {31'h0, irq}, 32'h1);
		bus(1'b1, IDX_LO_TWO, 8'h3C);
		poll("ool2", IDX_ST_ONE, 8'h60);
		bus(1'b1, IDX_MASK_ONE, 8'h60);
		chk("irq masked", {31'h0, irq}, 32'h0);
		bus(1'b1, IDX_HI_ONE, 8'hFF);
		bus(1'b1, IDX_LO_TWO, 8'h00);
		bus(1'b1, IDX_CLR_ONE, 8'h60);
		poll("ool clear", IDX_ST_ONE, 8'h00);
		bus(1'b1, IDX_MASK_ONE, 8'h00);
	endtask

	task automatic t_fault;
		slow <= 1'b1;
		bus(1'b1, IDX_CFG_THREE, 8'hC0);
		pollm(3'b110, 3'b111);
		fault <= 4'b1101;
		poll("nc therm", IDX_ST_TWO, 8'h34);
		bus(1'b1, IDX_MASK_TWO, 8'h0C);
		chk("irq nc", {31'h0, irq}, 32'h1);
		bus(1'b1, IDX_CFG_TWO, 8'h90);
		pollm(3'b001, 3'b001);
		fault <= 4'b0010;
		bus(1'b1, IDX_MASK_TWO, 8'h30);
		bus(1'b1, IDX_MASK_ONE, 8'h20);
		bus(1'b1, IDX_CLR_TWO, 8'hFF);
		poll("nc diode2", IDX_ST_TWO, 8'h08);
		chk("irq d2", {31'h0, irq}, 32'h1);
		fault <= 4'b0000;
		bus(1'b1, IDX_CLR_TWO, 8'hFF);
		poll("nc clear", IDX_ST_TWO, 8'h00);
		chk("irq off", {31'h0, irq}, 32'h0);
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		#(8 * 90000);
		err_total++;
		end_of_test();
	end

	initial begin
		repeat (6) @(posedge clk_i);
		resetn_i <= 1'b1;
		t_reset();
		t_sat();
		t_limit();
		t_fault();
		end_of_test();
	end
endmodule // dual_input_channel_config_bench
`default_nettype wire

// file: hw/dic_pkg.sv
// Functional notes
// [R1] shared inputs default to thermistor function
// [R2] config three bits 7,6 pick thermistor/voltage
// [R3] config two bit 7 selects second diode
// [R4] diode open/short in status two bits 2,3
// [R5] thermistor open/short in status two bits 4,5
// [R6] first shared channel limits set status one bit 6
// [R7] second shared channel limits set status one bit 5
// [R8] software masks diode faults in thermistor use
// [R9] software masks thermistor faults in diode use
// [R10] software turns fan control off for voltage
// [R11] result saturates to 0..255, unsigned eight bit
// [R12] local and remote diode channels always measured
// [R13] diode current base/N1 then base/N2, corrected
// [R14] average sixteen cycles before result update
// [R15] function change applies from next channel cycle
`default_nettype none
package dic_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned RAW_W  = 11;
	localparam logic [5:0] IDX_CFG_TWO   = 6'h01;
	localparam logic [5:0] IDX_CFG_THREE = 6'h02;
	localparam logic [5:0] IDX_FAN_CFG   = 6'h05;
	localparam logic [5:0] IDX_RES_SH1   = 6'h0A;
	localparam logic [5:0] IDX_RES_SH2   = 6'h0B;
	localparam logic [5:0] IDX_RES_REM1  = 6'h0D;
	localparam logic [5:0] IDX_RES_LOC   = 6'h0E;
	localparam logic [5:0] IDX_ST_ONE    = 6'h10;
	localparam logic [5:0] IDX_ST_TWO    = 6'h11;
	localparam logic [5:0] IDX_MASK_ONE  = 6'h12;
	localparam logic [5:0] IDX_MASK_TWO  = 6'h13;
	localparam logic [5:0] IDX_LO_ONE    = 6'h14;
	localparam logic [5:0] IDX_HI_ONE    = 6'h15;
	localparam logic [5:0] IDX_LO_TWO    = 6'h16;
	localparam logic [5:0] IDX_HI_TWO    = 6'h17;
	localparam logic [5:0] IDX_CLR_ONE   = 6'h1E;
	localparam logic [5:0] IDX_CLR_TWO   = 6'h1F;
	localparam int unsigned CFG2_SECOND_REMOTE_DIODE_BIT = 7;
	localparam int unsigned CFG2_AVG_OFF_BIT = 4;
	localparam int unsigned CFG3_TH1_BIT = 7;
	localparam int unsigned CFG3_TH2_BIT = 6;
	localparam int unsigned ST1_SH1_OOL_BIT = 6;
	localparam int unsigned ST1_SH2_OOL_BIT = 5;
	localparam int unsigned ST2_REM1_NC_BIT = 2;
	localparam int unsigned ST2_SECOND_REMOTE_DIODE_NC_BIT = 3;
	localparam int unsigned ST2_TH1_NC_BIT = 4;
	localparam int unsigned ST2_TH2_NC_BIT = 5;
	localparam logic [7:0] RST_CFG_TWO   = 8'h00;
	localparam logic [7:0] RST_CFG_THREE = 8'hC0;
	localparam logic [7:0] RST_FAN_CFG   = 8'h00;
	localparam logic [7:0] RST_MASK      = 8'h00;
	localparam logic [7:0] RST_LO_LIMIT  = 8'h00;
	localparam logic [7:0] RST_HI_LIMIT  = 8'hFF;
	localparam logic [1:0] CH_LOCAL = 2'h0;
	localparam logic [1:0] CH_REM1  = 2'h1;
	localparam logic [1:0] CH_SH1   = 2'h2;
	localparam logic [1:0] CH_SH2   = 2'h3;
	localparam logic [1:0] CUR_BASE = 2'h0;
	localparam logic [1:0] CUR_N1   = 2'h1;
	localparam logic [1:0] CUR_N2   = 2'h2;
	localparam logic [3:0] AVG_LAST = 4'hF;
	localparam logic [7:0] SAT_MAX  = 8'hFF;
	typedef enum logic [1:0] {ST_SETUP, ST_WAIT, ST_DONE} dic_state_e;
endpackage
`default_nettype wire

// file: hw/dic_top.sv
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dic_top
	import dic_pkg::*;
(
	input  wire logic                     clk_i,
	input  wire logic                     resetn_i,
	input  wire logic [ADDR_W-1:0]        avs_address_i,
	input  wire logic                     avs_read_i,
	input  wire logic                     avs_write_i,
	input  wire logic [DATA_W-1:0]        avs_writedata_i,
	input  wire logic [3:0]               avs_byteenable_i,
	output logic      [DATA_W-1:0]        avs_readdata_o,
	output logic                          avs_waitrequest_o,
	output logic                          adc_start_o,
	output logic      [1:0]               adc_chan_o,
	output logic      [1:0]               adc_cur_o,
	input  wire logic                     adc_done_i,
	input  wire logic signed [RAW_W-1:0]  adc_raw_i,
	input  wire logic [3:0]               sensor_fault_i,
	output logic                          thermistor_one_o,
	output logic                          thermistor_two_o,
	output logic                          second_remote_diode_o,
	output logic                          irq_o
);

	function automatic logic [7:0] sat8(input logic signed [13:0] v);
		if (v < 0)
			return 8'h00;
		else if (v > 14'sd255)
			return SAT_MAX;
		else
			return v[7:0];
	endfunction

	function automatic logic hit(input logic en, input logic [5:0] a,
		input logic [5:0] b);
		return en && (a == b);
	endfunction

	logic              ack_ff;
	logic [31:0]       rdata_ff;
	logic [7:0]        cfg2_ff;
	logic [7:0]        cfg3_ff;
	logic [7:0]        fan_ff;
	logic [7:0]        mask1_ff;
	logic [7:0]        mask2_ff;
	logic [7:0]        lo1_ff;
	logic [7:0]        hi1_ff;
	logic [7:0]        lo2_ff;
	logic [7:0]        hi2_ff;
	logic [7:0]        st1_ff;
	logic [7:0]        st2_ff;
	logic [3:0]        flt_meta_ff;
	logic [3:0]        flt_sync_ff;
	dic_state_e        state_ff;
	logic [1:0]        ch_ff;
	logic [1:0]        step_ff;
	logic [3:0]        round_ff;
	logic [RAW_W-1:0]  smp_ff [4];
	logic [11:0]       acc_ff [4];
	logic [7:0]        res_ff [4];
	logic              second_remote_diode_act_ff;
	logic [1:0]        th_act_ff;
	logic              start_ff;
	logic [1:0]        chan_ff;
	logic [1:0]        cur_ff;

	wire logic [5:0] reg_idx = avs_address_i[7:2];
	wire logic       req     = avs_read_i | avs_write_i;
	wire logic       nxt_ack = req & ~ack_ff;
	wire logic       wr_en   = avs_write_i & ack_ff & avs_byteenable_i[0]
		& (avs_address_i[1:0] == 2'h0);
	wire logic [7:0] wbyte   = avs_writedata_i[7:0];
	wire logic [7:0] clr1    = hit(wr_en, reg_idx, IDX_CLR_ONE) ? wbyte
		: 8'h00;
	wire logic [7:0] clr2    = hit(wr_en, reg_idx, IDX_CLR_TWO) ? wbyte
		: 8'h00;

	// a request is stalled one cycle so read data come from a flop
	assign avs_waitrequest_o = nxt_ack;
	assign avs_readdata_o    = rdata_ff;

	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		if (avs_address_i[1:0] == 2'h0) begin
			unique case (reg_idx)
				IDX_CFG_TWO:   rd_mux = cfg2_ff;
				IDX_CFG_THREE: rd_mux = cfg3_ff;
				IDX_FAN_CFG:   rd_mux = fan_ff;
				IDX_RES_SH1:   rd_mux = res_ff[CH_SH1];
				IDX_RES_SH2:   rd_mux = res_ff[CH_SH2];
				IDX_RES_REM1:  rd_mux = res_ff[CH_REM1];
				IDX_RES_LOC:   rd_mux = res_ff[CH_LOCAL];
				IDX_ST_ONE:    rd_mux = st1_ff;
				IDX_ST_TWO:    rd_mux = st2_ff;
				IDX_MASK_ONE:  rd_mux = mask1_ff;
				IDX_MASK_TWO:  rd_mux = mask2_ff;
				IDX_LO_ONE:    rd_mux = lo1_ff;
				IDX_HI_ONE:    rd_mux = hi1_ff;
				IDX_LO_TWO:    rd_mux = lo2_ff;
				IDX_HI_TWO:    rd_mux = hi2_ff;
				default:       rd_mux = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ack_ff   <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= nxt_ack;
			if (avs_read_i && nxt_ack)
				rdata_ff <= {24'h000000, rd_mux};
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cfg2_ff  <= RST_CFG_TWO;
			cfg3_ff  <= RST_CFG_THREE; // see [R1]
			fan_ff   <= RST_FAN_CFG;
			mask1_ff <= RST_MASK;
			mask2_ff <= RST_MASK;
			lo1_ff   <= RST_LO_LIMIT;
			hi1_ff   <= RST_HI_LIMIT;
			lo2_ff   <= RST_LO_LIMIT;
			hi2_ff   <= RST_HI_LIMIT;
		end else begin
			if (hit(wr_en, reg_idx, IDX_CFG_TWO))   cfg2_ff  <= wbyte;
			if (hit(wr_en, reg_idx, IDX_CFG_THREE)) cfg3_ff  <= wbyte;
			if (hit(wr_en, reg_idx, IDX_FAN_CFG))   fan_ff   <= wbyte;
			if (hit(wr_en, reg_idx, IDX_MASK_ONE))  mask1_ff <= wbyte;
			if (hit(wr_en, reg_idx, IDX_MASK_TWO))  mask2_ff <= wbyte;
			if (hit(wr_en, reg_idx, IDX_LO_ONE))    lo1_ff   <= wbyte;
			if (hit(wr_en, reg_idx, IDX_HI_ONE))    hi1_ff   <= wbyte;
			if (hit(wr_en, reg_idx, IDX_LO_TWO))    lo2_ff   <= wbyte;
			if (hit(wr_en, reg_idx, IDX_HI_TWO))    hi2_ff   <= wbyte;
		end
	end

	// fault comparators sit in the analog domain
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			flt_meta_ff <= 4'h0;
			flt_sync_ff <= 4'h0;
		end else begin
			flt_meta_ff <= sensor_fault_i;
			flt_sync_ff <= flt_meta_ff;
		end
	end

	// measurement sequencer
	wire logic cur_diode = (ch_ff == CH_LOCAL) || (ch_ff == CH_REM1)
		|| ((ch_ff == CH_SH1) && second_remote_diode_act_ff); // see [R3]
	wire logic last_step = cur_diode ? (step_ff == 2'h3)
		: (step_ff == 2'h0);
	wire logic [1:0] step_cur = (step_ff == 2'h1) ? CUR_N1
		: (step_ff == 2'h3) ? CUR_N2 : CUR_BASE; // see [R13]
	// pair two skips its slot while the pins carry a diode
	wire logic [1:0] ch_inc  = ch_ff + 2'h1;
	wire logic [1:0] nxt_ch  = ((ch_inc == CH_SH2) && second_remote_diode_act_ff)
		? CH_LOCAL : ch_inc; // see [R12]
	wire logic mode_ld = (state_ff == ST_DONE) && (nxt_ch == CH_SH1);

	wire logic signed [13:0] e0 = 14'(signed'(smp_ff[0]));
	wire logic signed [13:0] e1 = 14'(signed'(smp_ff[1]));
	wire logic signed [13:0] e2 = 14'(signed'(smp_ff[2]));
	wire logic signed [13:0] e3 = 14'(signed'(smp_ff[3]));
	// two deltas cancel the series drop: 2*dV1 - dV2
	wire logic signed [13:0] diode_t = ((e1 - e0) <<< 1) - (e3 - e2);
	wire logic [7:0] value = cur_diode ? sat8(diode_t)
		: sat8(e0); // see [R11] see [R13]
	wire logic avg_off = cfg2_ff[CFG2_AVG_OFF_BIT];
	wire logic [11:0] acc_sum = acc_ff[ch_ff] + {4'h0, value};
	wire logic res_upd = (state_ff == ST_DONE)
		&& (avg_off || (round_ff == AVG_LAST)); // see [R14]
	wire logic [7:0] nxt_res = avg_off ? value : acc_sum[11:4];
	wire logic ool_one = res_upd && (ch_ff == CH_SH1)
		&& ((nxt_res < lo1_ff) || (nxt_res > hi1_ff)); // see [R6]
	wire logic ool_two = res_upd && (ch_ff == CH_SH2)
		&& ((nxt_res < lo2_ff) || (nxt_res > hi2_ff)); // see [R7]

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_ff    <= ST_SETUP;
			ch_ff       <= CH_LOCAL;
			step_ff     <= 2'h0;
			round_ff    <= 4'h0;
			second_remote_diode_act_ff <= 1'b0;
			th_act_ff   <= 2'b11; // see [R1]
			start_ff    <= 1'b0;
			chan_ff     <= CH_LOCAL;
			cur_ff      <= CUR_BASE;
		end else begin
			start_ff <= 1'b0;
			unique case (state_ff)
				ST_SETUP: begin
					chan_ff  <= ch_ff;
					cur_ff   <= step_cur;
					start_ff <= 1'b1;
					state_ff <= ST_WAIT;
				end
				ST_WAIT: begin
					if (adc_done_i) begin
						step_ff  <= last_step ? step_ff : step_ff + 2'h1;
						state_ff <= last_step ? ST_DONE : ST_SETUP;
					end
				end
				ST_DONE: begin
					step_ff  <= 2'h0;
					ch_ff    <= nxt_ch;
					state_ff <= ST_SETUP;
					if (nxt_ch == CH_LOCAL)
						round_ff <= round_ff + 4'h1;
					// mode latched between conversions only
					if (mode_ld) begin
						second_remote_diode_act_ff <= cfg2_ff[CFG2_SECOND_REMOTE_DIODE_BIT]; // see [R3] see [R15]
						th_act_ff   <= {cfg3_ff[CFG3_TH1_BIT],
							cfg3_ff[CFG3_TH2_BIT]}; // see [R2] see [R15]
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < 4; i++) begin
				smp_ff[i] <= '0;
				acc_ff[i] <= 12'h000;
				res_ff[i] <= 8'h00;
			end
		end else begin
			if ((state_ff == ST_WAIT) && adc_done_i)
				smp_ff[step_ff] <= adc_raw_i;
			if (state_ff == ST_DONE) begin
				acc_ff[ch_ff] <= res_upd ? 12'h000 : acc_sum; // see [R14]
				if (res_upd)
					res_ff[ch_ff] <= nxt_res;
			end
		end
	end

	// status: hardware set wins over a clear in the same cycle
	logic [7:0] set1;
	logic [7:0] set2;
	always_comb begin
		set1 = 8'h00;
		set2 = 8'h00;
		set1[ST1_SH1_OOL_BIT] = ool_one; // see [R6]
		set1[ST1_SH2_OOL_BIT] = ool_two; // see [R7]
		set2[ST2_REM1_NC_BIT] = flt_sync_ff[0]; // see [R4]
		set2[ST2_SECOND_REMOTE_DIODE_NC_BIT] = flt_sync_ff[1] & second_remote_diode_act_ff; // see [R4]
		set2[ST2_TH1_NC_BIT]  = flt_sync_ff[2] & th_act_ff[1]
			& ~second_remote_diode_act_ff; // see [R5]
		set2[ST2_TH2_NC_BIT]  = flt_sync_ff[3] & th_act_ff[0]
			& ~second_remote_diode_act_ff; // see [R5]
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st1_ff <= 8'h00;
			st2_ff <= 8'h00;
		end else begin
			st1_ff <= (st1_ff & ~clr1) | set1;
			st2_ff <= (st2_ff & ~clr2) | set2;
		end
	end

	// a set mask bit silences its status bit, as software expects
	assign irq_o = |(st1_ff & ~mask1_ff) | |(st2_ff & ~mask2_ff);
	assign adc_start_o = start_ff;
	assign adc_chan_o  = chan_ff;
	assign adc_cur_o   = cur_ff;
	assign thermistor_one_o      = th_act_ff[1];
	assign thermistor_two_o      = th_act_ff[0];
	assign second_remote_diode_o = second_remote_diode_act_ff;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	property p_por;
		$rose(resetn_i) |-> thermistor_one_o && thermistor_two_o
			&& !second_remote_diode_o;
	endproperty
	a_por: assert property (p_por) else $error("bad mode after reset"); // see [R1]

	property p_th_sel;
		mode_ld |=> ({thermistor_one_o, thermistor_two_o}
			== $past(cfg3_ff[7:6]));
	endproperty
	a_th_sel: assert property (p_th_sel) else $error("thermistor select"); // see [R2]

	property p_second_remote_diode;
		(mode_ld && cfg2_ff[CFG2_SECOND_REMOTE_DIODE_BIT]) |=> second_remote_diode_o
			&& (ch_ff == CH_SH1) ##1 (adc_chan_o == CH_SH1);
	endproperty
	a_second_remote_diode: assert property (p_second_remote_diode) else $error("diode pair mode"); // see [R3]

	property p_rem_nc;
		flt_sync_ff[0] |=> st2_ff[ST2_REM1_NC_BIT];
	endproperty
	a_rem_nc: assert property (p_rem_nc) else $error("diode fault lost"); // see [R4]

	property p_th_nc;
		(flt_sync_ff[2] && thermistor_one_o && !second_remote_diode_o)
			|=> st2_ff[ST2_TH1_NC_BIT];
	endproperty
	a_th_nc: assert property (p_th_nc) else $error("thermistor fault"); // see [R5]

	// an unmasked limit hit must also raise the interrupt line
	property p_ool_one;
		ool_one |=> st1_ff[ST1_SH1_OOL_BIT]
			&& (irq_o || mask1_ff[ST1_SH1_OOL_BIT]);
	endproperty
	a_ool_one: assert property (p_ool_one) else $error("ch one limit"); // see [R6]

	property p_ool_two;
		ool_two |=> st1_ff[ST1_SH2_OOL_BIT];
	endproperty
	a_ool_two: assert property (p_ool_two) else $error("ch two limit"); // see [R7]

	property p_clr;
		(clr2[ST2_REM1_NC_BIT] && !set2[ST2_REM1_NC_BIT])
			|=> !st2_ff[ST2_REM1_NC_BIT];
	endproperty
	a_clr: assert property (p_clr) else $error("status not cleared"); // see [R4]

	property p_sat;
		(res_upd && avg_off && (ch_ff == CH_SH1) && !cur_diode
			&& (e0 > 14'sd255)) |=> (res_ff[CH_SH1] == SAT_MAX);
	endproperty
	a_sat: assert property (p_sat) else $error("no saturation"); // see [R11]

	property p_seq;
		((state_ff == ST_DONE) && (ch_ff == CH_LOCAL))
			|=> ##1 (adc_chan_o == CH_REM1);
	endproperty
	a_seq: assert property (p_seq) else $error("remote skipped"); // see [R12]

	property p_cur;
		(adc_start_o && (step_ff == 2'h3)) |-> (adc_cur_o == CUR_N2);
	endproperty
	a_cur: assert property (p_cur) else $error("bad current step"); // see [R13]

	property p_avg;
		$changed(res_ff[CH_LOCAL]) |-> ($past(round_ff) == AVG_LAST)
			|| $past(avg_off);
	endproperty
	a_avg: assert property (p_avg) else $error("early update"); // see [R14]

	property p_hold;
		!mode_ld |=> $stable({thermistor_one_o, thermistor_two_o,
			second_remote_diode_o});
	endproperty
	a_hold: assert property (p_hold) else $error("mode changed mid cycle"); // see [R15]

	c_second_remote_diode: cover property (second_remote_diode_o && res_upd
		&& ch_ff == CH_SH1);
	c_irq: cover property ($rose(irq_o));
	c_avg: cover property (res_upd && !avg_off);
	c_th_nc: cover property (st2_ff[ST2_TH1_NC_BIT]);
	c_ool: cover property (ool_two);

endmodule // dic_top
`default_nettype wire
